// *** include/aac_pkg.sv ***
// Package holding constants and types for the converter autoscan control.
`default_nettype none
package aac_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned RES_W = 10;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned BIT_PERIODS = 10;
  localparam int unsigned SAMPLE_BITS = 2;
  // Bit times per conversion: sample (2) plus decisions (10), m/2 each.
  localparam logic [4:0] BITS_PER_CONV = 5'h0c;
  // Idle period of m-1 cycles after store; 12*m/2 + 1 + init = 7*m.
  localparam logic [3:0] HALF_M_CYC_W = 4'h4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [1:0] EDGE_NONE = 2'h0;

  // Control bits presented to the block as one group.
  typedef struct packed {
    logic [1:0] prescale_sel;
    logic continuous_scan_sel;
    logic ext_rise_enable;
    logic ext_fall_enable;
  } aac_ctrl_t;

  // One stored result with its channel.
  typedef struct packed {
    logic [2:0] chan;
    logic [9:0] code;
  } aac_result_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ALIGN = 5'h02,
    ST_CONV = 5'h04,
    ST_STORE = 5'h08,
    ST_INIT = 5'h10
  } aac_state_t;
endpackage
`default_nettype wire

// *** rtl/aac_adc_autoscan_control.sv ***
// Autoscan sequencer for a 10-bit successive-approximation converter.
// Summary of operation
// - Ten-bit successive approximation over eight multiplexed inputs.
// - Two-bit prescaler field selects divisor m of 2, 4, 6 or 8.
// - Conversion lasts 6m+1 cycles: sample, ten bits, one store cycle.
// - Initialisation after store spaces conversions 7m cycles apart.
// - First sampling aligns to divided clock, delayed up to m/2 cycles.
// - Every conversion is an autoscan, continuous or one-time.
// - Channels with mask bit one are scanned, zero bits skipped.
// - Each scan starts at the lowest set mask bit.
// - Loop starts when start flag sets by software or external edge.
// - Two enables choose no, rising, falling or both external edges.
// - Result stored in channel buffer, then next higher set bit converted.
// - Last store sets done flag; only a software write or reset clears it.
// - Continuous keeps start set and restarts; one-time stops, clears start.
// - Start writes while done flag set wait pending; start reads zero.
// - Reset clears control, mask and shared high bits; result buffers keep their contents.
// - Power-down aborts, clears start, halts divider.
`default_nettype none
module aac_adc_autoscan_control (
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic [1:0] PRESCALE_SEL_I,
  input wire logic CONTINUOUS_SCAN_SEL_I,
  input wire logic EXT_RISE_ENABLE_I,
  input wire logic EXT_FALL_ENABLE_I,
  input wire logic [7:0] SCAN_SELECT_MASK_I,
  input wire logic CTRL_WRITE_I,
  input wire logic START_WRITE_VAL_I,
  input wire logic DONE_CLEAR_I,
  input wire logic POWER_DOWN_I,
  input wire logic EXT_START_IN_I,
  input wire logic COMP_I,
  input wire logic [2:0] READ_CHAN_I,
  output logic CONV_START_FLAG_O,
  output logic SCAN_DONE_FLAG_O,
  output logic BUSY_O,
  output logic [2:0] MUX_SEL_O,
  output logic SAMPLE_O,
  output logic [9:0] DAC_CODE_O,
  output logic [7:0] RESULT_LOW_BYTE_O,
  output logic [1:0] RESULT_HIGH_BITS_O,
  output logic RESULT_STROBE_O
);

  // Latched configuration, sequencer state and flags.
  aac_pkg::aac_ctrl_t ctrl;
  aac_pkg::aac_state_t state;
  aac_pkg::aac_state_t next_state;
  logic [7:0] scan_select_mask;
  logic start_flag;
  logic start_pending;
  logic done_flag;

  // External start synchroniser and its settled copy.
  logic [2:0] ext_sync;
  logic ext_stable;

  // Divider, bit counter, channel pointer and approximation register.
  logic [3:0] cyc_cnt;
  logic [4:0] bit_idx;
  logic [2:0] chan;
  logic [9:0] sar;
  logic [9:0] trial;

  // Result storage; only the two top bits are shared between channels.
  logic [9:0] result_mem [0:7];
  logic [1:0] last_high;
  logic strobe;

  // Decoded helper wires.
  logic div_tick;
  logic [3:0] half_m;
  logic [2:0] first_chan;
  logic [2:0] next_chan;
  logic has_next;
  logic any_sel;
  logic ext_rise;
  logic ext_fall;
  logic ext_trig;
  logic start_req;
  logic last_conv;
  logic conv_done;
  logic init_done;
  logic [3:0] bit_pos;

  // Divisor m = 2*(sel+1); half of it is the divided-clock tick period.
  // A machine cycle is one system clock here, so at 20 MHz even m = 8
  // gives a conversion far shorter than 15 us; software must slow the
  // clock if converter accuracy depends on it.
  assign half_m = {2'h0, ctrl.prescale_sel} + 4'h1;
  assign div_tick = (cyc_cnt == half_m - 4'h1);

  // Lowest set mask bit starts the loop; next higher set bit follows it.
  // A mask write in mid-scan steers only the channels still to come.
  always_comb begin
    first_chan = 3'h0;
    next_chan = 3'h0;
    has_next = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (scan_select_mask[i]) begin
        first_chan = 3'(i);
      end
      if (scan_select_mask[i] && (3'(i) > chan)) begin
        next_chan = 3'(i);
        has_next = 1'b1;
      end
    end
  end
  assign any_sel = |scan_select_mask;
  assign last_conv = ~has_next;

  // Edge detection only on agreeing second and third stages.
  // The settled copy resets low; a pin held high through reset is
  // absorbed while the edge enables are still off after reset.
  assign ext_rise = ext_sync[1] & ext_sync[2] & ~ext_stable;
  assign ext_fall = ~ext_sync[1] & ~ext_sync[2] & ext_stable;
  assign ext_trig = (ext_rise & ctrl.ext_rise_enable) |
                    (ext_fall & ctrl.ext_fall_enable);
  assign start_req = (CTRL_WRITE_I & START_WRITE_VAL_I) | ext_trig;

  // Bit timing inside one conversion.
  assign bit_pos = 4'(aac_pkg::BITS_PER_CONV - 5'h1 - bit_idx);
  // One-hot mask of the bit whose decision is due at the current tick.
  assign trial = 10'h001 << bit_pos;
  assign conv_done = div_tick && (bit_idx == aac_pkg::BITS_PER_CONV - 5'h1);
  assign init_done = (cyc_cnt == (half_m << 1) - 4'h2);

  // Sequencer state selection.
  // Idle leaves only with an enabled channel; an empty mask keeps the
  // start flag up without converting anything.
  always_comb begin
    next_state = state;
    unique case (state)
      aac_pkg::ST_IDLE: begin
        if (start_flag && any_sel) begin
          next_state = aac_pkg::ST_ALIGN;
        end
      end
      aac_pkg::ST_ALIGN: begin
        if (div_tick) begin
          next_state = aac_pkg::ST_CONV;
        end
      end
      aac_pkg::ST_CONV: begin
        if (conv_done) begin
          next_state = aac_pkg::ST_STORE;
        end
      end
      aac_pkg::ST_STORE: begin
        if (last_conv && !ctrl.continuous_scan_sel) begin
          next_state = aac_pkg::ST_IDLE;
        end else begin
          next_state = aac_pkg::ST_INIT;
        end
      end
      aac_pkg::ST_INIT: begin
        if (init_done) begin
          next_state = aac_pkg::ST_CONV;
        end
      end
      default: begin
        next_state = aac_pkg::ST_IDLE;
      end
    endcase
  end

  // Control and mask clear on reset; power-down leaves them alone.
  // Changing the prescaler while busy can stretch one divider tick.
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctrl <= '0;
      scan_select_mask <= aac_pkg::MASK_RESET;
    end else if (CTRL_WRITE_I) begin
      ctrl <= '{PRESCALE_SEL_I, CONTINUOUS_SCAN_SEL_I,
                EXT_RISE_ENABLE_I, EXT_FALL_ENABLE_I};
      scan_select_mask <= SCAN_SELECT_MASK_I;
    end
  end

  // Three-stage synchroniser; the stable copy follows agreeing stages.
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ext_sync <= 3'h0;
      ext_stable <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[1:0], EXT_START_IN_I};
      if (ext_sync[1] == ext_sync[2]) begin
        ext_stable <= ext_sync[2];
      end
    end
  end

  // Start, pending and done flags. Hardware set wins over software clear.
  // A start that arrives while done is up waits in the pending bit and
  // takes effect on the cycle after done clears.
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      start_flag <= 1'b0;
      start_pending <= 1'b0;
      done_flag <= 1'b0;
    end else begin
      if (state == aac_pkg::ST_STORE && last_conv) begin
        done_flag <= 1'b1;
      end else if (DONE_CLEAR_I) begin
        done_flag <= 1'b0;
      end
      if (POWER_DOWN_I) begin
        start_flag <= 1'b0;
        start_pending <= 1'b0;
      end else if (state == aac_pkg::ST_STORE && last_conv &&
                   !ctrl.continuous_scan_sel) begin
        start_flag <= 1'b0;
        start_pending <= start_pending | start_req;
      end else if (done_flag) begin
        start_pending <= start_pending | start_req;
      end else if (start_req || start_pending) begin
        start_flag <= 1'b1;
        start_pending <= 1'b0;
      end
    end
  end

  // Sequencer, divider and successive-approximation register.
  // Power-down parks everything here but keeps the channel and code.
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state <= aac_pkg::ST_IDLE;
      cyc_cnt <= 4'h0;
      bit_idx <= 5'h0;
      chan <= 3'h0;
      sar <= 10'h000;
      strobe <= 1'b0;
    end else if (POWER_DOWN_I) begin
      state <= aac_pkg::ST_IDLE;
      cyc_cnt <= 4'h0;
      bit_idx <= 5'h0;
      strobe <= 1'b0;
    end else begin
      state <= next_state;
      strobe <= (state == aac_pkg::ST_STORE);
      // The divider free-runs in idle so a start aligns to its phase.
      if (state == aac_pkg::ST_INIT) begin
        cyc_cnt <= init_done ? 4'h0 : cyc_cnt + 4'h1;
      end else if (state == aac_pkg::ST_STORE) begin
        cyc_cnt <= 4'h0;
      end else begin
        cyc_cnt <= div_tick ? 4'h0 : cyc_cnt + 4'h1;
      end
      if (state == aac_pkg::ST_IDLE) begin
        chan <= first_chan;
      end
      // Two sample ticks, then one decision per tick, MSB first.
      if (state == aac_pkg::ST_CONV && div_tick) begin
        bit_idx <= bit_idx + 5'h1;
        if (bit_idx == 5'h1) begin
          sar <= 10'h200;
        end else if (bit_idx > 5'h1) begin
          // Drop the trial bit if the input is below it, then try the
          // next lower one; after bit zero the shift leaves nothing.
          sar <= (COMP_I ? sar : (sar & ~trial)) | (trial >> 1);
        end
      end
      if (state == aac_pkg::ST_STORE) begin
        bit_idx <= 5'h0;
        chan <= last_conv ? first_chan : next_chan;
      end
    end
  end

  // Result buffers have no reset so contents survive reset and power-down.
  // Reading a buffer before its first store returns an unknown value.
  always_ff @(posedge SYS_CLK_I) begin
    if (state == aac_pkg::ST_STORE) begin
      result_mem[chan] <= sar;
    end
  end

  // The shared high bits hold the last stored result's top two bits.
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      last_high <= 2'h0;
    end else if (state == aac_pkg::ST_STORE) begin
      last_high <= sar[9:8];
    end
  end

  // Port views. A held start stays invisible while the done flag is up.
  assign CONV_START_FLAG_O = start_flag & ~done_flag;
  assign SCAN_DONE_FLAG_O = done_flag;
  assign BUSY_O = (state != aac_pkg::ST_IDLE);
  assign MUX_SEL_O = chan;
  assign SAMPLE_O = (state == aac_pkg::ST_CONV) && (bit_idx < 5'h2);
  assign DAC_CODE_O = sar;
  assign RESULT_LOW_BYTE_O = result_mem[READ_CHAN_I][7:0];
  assign RESULT_HIGH_BITS_O = last_high;
  assign RESULT_STROBE_O = strobe;

endmodule
`default_nettype wire

// *** testbench/aac_props.sv ***
// Port-level concurrent checks for the autoscan control.
`default_nettype none
module aac_props (
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic [7:0] SCAN_SELECT_MASK_I,
  input wire logic DONE_CLEAR_I,
  input wire logic POWER_DOWN_I,
  input wire logic CONV_START_FLAG_O,
  input wire logic SCAN_DONE_FLAG_O,
  input wire logic BUSY_O,
  input wire logic [2:0] MUX_SEL_O,
  input wire logic SAMPLE_O,
  input wire logic RESULT_STROBE_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // The done flag survives everything except a software clear or reset.
  property p_done_hold;
    SCAN_DONE_FLAG_O && !DONE_CLEAR_I |=> SCAN_DONE_FLAG_O;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done lost");
  property p_done_sw;
    $fell(SCAN_DONE_FLAG_O) |-> $past(DONE_CLEAR_I);
  endproperty
  a_done_sw: assert property (p_done_sw) else $error("done cleared");
  // A set done flag hides the start flag from readers.
  property p_start_hidden;
    SCAN_DONE_FLAG_O |-> !CONV_START_FLAG_O;
  endproperty
  a_start_hidden: assert property (p_start_hidden) else $error("start");
  // Each strobe lasts exactly one cycle.
  property p_strobe_one;
    RESULT_STROBE_O |=> !RESULT_STROBE_O;
  endproperty
  a_strobe_one: assert property (p_strobe_one) else $error("strobe");
  property p_done_store;
    $rose(SCAN_DONE_FLAG_O) |-> RESULT_STROBE_O;
  endproperty
  a_done_store: assert property (p_done_store) else $error("no store");
  // Power-down must stop the sequencer within two cycles.
  property p_pd_abort;
    $rose(POWER_DOWN_I) |-> ##[0:2] (!BUSY_O && !CONV_START_FLAG_O);
  endproperty
  a_pd_abort: assert property (p_pd_abort) else $error("no abort");
  // Only masked-in channels are ever sampled.
  property p_mask_member;
    SAMPLE_O |-> SCAN_SELECT_MASK_I[MUX_SEL_O];
  endproperty
  a_mask_member: assert property (p_mask_member) else $error("mask");
  property p_sample_len;
    $rose(SAMPLE_O) |=> SAMPLE_O || POWER_DOWN_I;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sample");
  c_done: cover property ($rose(SCAN_DONE_FLAG_O));
  c_pd_busy: cover property (BUSY_O && POWER_DOWN_I);
  c_strobe: cover property (RESULT_STROBE_O);
endmodule
`default_nettype wire

// *** testbench/aac_sar_model.sv ***
// Comparator and ladder model: each channel has a fixed input voltage.
`default_nettype none
module aac_sar_model (
  input wire logic [2:0] mux_sel_i,
  input wire logic [9:0] dac_code_i,
  output logic comp_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Input of channel c is {c, c, 4'h5}; comparison is ideal.
  assign comp_o = {mux_sel_i, mux_sel_i, 4'h5} >= dac_code_i;
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the autoscan control.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [1:0] p; logic [7:0] m; logic [2:0] lo_ch, hi_ch; logic [3:0] n;
  } aac_row_t;
  aac_row_t rows [4] = '{'{0, 8'h81, 0, 7, 2}, '{1, 8'h06, 1, 2, 2},
    '{2, 8'h10, 4, 4, 1}, '{3, 8'hff, 0, 7, 8}};
  logic clk = 0, rst_n = 0, wr = 0, sv = 0, clr = 0, pd = 0, ext = 0;
  logic cont = 0, re = 0, fe = 0, cmp, st, dn, bz, smp, stb, seen;
  logic [1:0] ps = 0, hi;
  logic [7:0] msk = 0, lo, v;
  logic [2:0] rch = 0, mx, first;
  logic [9:0] dac;
  int errors = 0, cmp_count = 0, cyc = 0, nstb = 0, t0, t1, ts, m;
  aac_adc_autoscan_control i_dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n),
    .PRESCALE_SEL_I(ps), .CONTINUOUS_SCAN_SEL_I(cont),
    .EXT_RISE_ENABLE_I(re), .EXT_FALL_ENABLE_I(fe),
    .SCAN_SELECT_MASK_I(msk), .CTRL_WRITE_I(wr), .START_WRITE_VAL_I(sv),
    .DONE_CLEAR_I(clr), .POWER_DOWN_I(pd), .EXT_START_IN_I(ext),
    .COMP_I(cmp), .READ_CHAN_I(rch), .CONV_START_FLAG_O(st),
    .SCAN_DONE_FLAG_O(dn), .BUSY_O(bz), .MUX_SEL_O(mx), .SAMPLE_O(smp),
    .DAC_CODE_O(dac), .RESULT_LOW_BYTE_O(lo), .RESULT_HIGH_BITS_O(hi),
    .RESULT_STROBE_O(stb));
  aac_sar_model i_model (.mux_sel_i(mx), .dac_code_i(dac), .comp_o(cmp));
  always #25 clk = ~clk;
  // Strobe count, strobe times and first sampled channel of a scan.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (stb === 1'b1) begin
      if (nstb == 0) t0 <= cyc;
      t1 <= cyc;
      nstb <= nstb + 1;
    end
    if (smp === 1'b1 && !seen) begin
      first <= mx;
      ts <= cyc;
      seen <= 1;
    end
    // Generous ceiling; the full run needs under a thousand cycles.
    if (cyc == 20000) begin
      errors++;
      test_done;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ctl(input logic [1:0] p, input logic c, r, f,
    input logic [7:0] mm, input logic s);
    @(negedge clk);
    {ps, cont, re, fe, msk, sv, wr} = {p, c, r, f, mm, s, 1'b1};
    @(negedge clk);
    wr = 0;
  endtask
  task automatic clear;
    @(negedge clk);
    clr = 1;
    @(negedge clk);
    clr = 0;
  endtask
  // Bounded wait; one more edge lets the monitor count the last strobe.
  task automatic wait_done;
    for (int i = 0; i < 3000 && dn !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    chk(16'(dn), 16'h1);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    chk(16'({st, dn, bz}), 16'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      nstb = 0;
      seen = 0;
      // Each row is software's choice of m; at this clock every choice
      // converts in well under 15 us, which the ideal model tolerates.
      m = 2 * (rows[i].p + 1);
      ctl(rows[i].p, 0, 0, 0, rows[i].m, 1);
      wait_done;
      chk(16'({dn, st}), 16'h2);
      chk(16'(nstb), 16'(rows[i].n));
      chk(16'(first), 16'(rows[i].lo_ch));
      chk(16'(hi), 16'(rows[i].hi_ch[2:1]));
      chk(16'(t1 - t0 >= (nstb - 1) * (7 * m - 1) &&
        t1 - t0 <= (nstb - 1) * (7 * m + 1)), 16'h1);
      chk(16'(t0 - ts), 16'(6 * m + 1));
      for (int c = 0; c < 8; c++) begin
        rch = 3'(c);
        #1 if (rows[i].m[c]) chk(16'(lo), 16'({rch[0], rch, 4'h5}));
      end
      clear;
      chk(16'(dn), 16'h0);
      $display("scan row %0d done", i);
    end
    ctl(0, 0, 0, 0, 8'h01, 1);
    wait_done;
    ctl(0, 0, 0, 0, 8'h01, 1);
    chk(16'({st, bz}), 16'h0);
    clear;
    repeat (3) @(negedge clk);
    chk(16'(bz), 16'h1);
    wait_done;
    clear;
    $display("pending start test done");
    ctl(0, 1, 0, 0, 8'h03, 1);
    wait_done;
    clear;
    repeat (2) @(negedge clk);
    chk(16'(st), 16'h1);
    rch = 0;
    #1 v = lo;
    pd = 1;
    repeat (3) @(negedge clk);
    chk(16'({st, bz, dn}), 16'h0);
    chk(16'(lo), 16'(v));
    pd = 0;
    repeat (3) @(negedge clk);
    chk(16'({st, bz}), 16'h0);
    $display("continuous and power-down test done");
    for (int e = 0; e < 4; e++) begin
      ctl(0, 0, e[1], e[0], 8'h01, 0);
      ext = 1;
      repeat (8) @(negedge clk);
      chk(16'(bz), 16'(e[1]));
      if (e[1]) begin
        wait_done;
        clear;
      end
      ext = 0;
      repeat (8) @(negedge clk);
      chk(16'(bz), 16'(e[0]));
      if (e[0]) begin
        wait_done;
        clear;
      end
    end
    $display("external start test done");
    rst_n = 0;
    repeat (2) @(negedge clk);
    rst_n = 1;
    chk(16'(lo), 16'(v));
    chk(16'({st, dn}), 16'h0);
    $display("second reset test done");
    test_done;
  end
endmodule
bind aac_adc_autoscan_control aac_props i_props (.SYS_CLK_I(SYS_CLK_I),
  .RESET_N_I(RESET_N_I), .SCAN_SELECT_MASK_I(SCAN_SELECT_MASK_I),
  .DONE_CLEAR_I(DONE_CLEAR_I), .POWER_DOWN_I(POWER_DOWN_I),
  .CONV_START_FLAG_O(CONV_START_FLAG_O), .SCAN_DONE_FLAG_O(SCAN_DONE_FLAG_O),
  .BUSY_O(BUSY_O), .MUX_SEL_O(MUX_SEL_O), .SAMPLE_O(SAMPLE_O),
  .RESULT_STROBE_O(RESULT_STROBE_O));
`default_nettype wire
